// ==== common/pcb_pkg.sv ====
// Constants and types shared by the memory-side register block and the controller.
// Assumes one core clock; all link signals sampled on it.
package pcb_pkg;
  localparam int ADDR_W = 23;
  localparam logic [22:0] TOP_ADDR = 23'h7fffff;
  localparam logic [15:0] SEL_REFRESH = 16'h0000;
  localparam logic [15:0] SEL_BUS = 16'h0001;
  localparam logic [15:0] BUS_SETUP_RESET = 16'h9d1f;
  localparam logic [15:0] REFRESH_SETUP_RESET = 16'h0010;
  localparam logic [1:0] PIN_SEL_BUS = 2'b10;
  localparam logic [1:0] PIN_SEL_REFRESH = 2'b00;
  localparam int PIN_SEL_LO = 18;
  localparam int BL_LO = 0;
  localparam int WRAP_BIT = 3;
  localparam int DRIVE_LO = 4;
  localparam logic [2:0] BL_CONT = 3'h7;
  localparam logic [1:0] DRIVE_FULL = 2'h0;
  localparam logic [1:0] DRIVE_HALF = 2'h1;
  localparam logic [1:0] DRIVE_QUARTER = 2'h2;
  // APB register offsets of the controller
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // Controller command codes (CTRL[2:0])
  typedef enum logic [2:0] {
    PCB_CMD_RD = 3'h0,
    PCB_CMD_WR = 3'h1,
    PCB_CMD_SW_LOAD = 3'h2,
    PCB_CMD_SW_READ = 3'h3
  } pcb_cmd_t;
  localparam int CTRL_GO = 3;
  localparam int CTRL_REGSEL = 4;
endpackage

// ==== common/pcb_if.sv ====
// Simplified memory link: one operation per strobe, on the core clock.
// Assumes the testbench connects the two modports and taps the link signals directly for the monitor.
`timescale 1ns/1ps
interface pcb_if;
  import pcb_pkg::*;
  logic op_valid;
  logic op_write;
  logic register_select_pin;
  logic [ADDR_W-1:0] op_addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  modport dev (input op_valid, input op_write, input register_select_pin, input op_addr,
    input wdata, output rdata, output rvalid);
  modport ctl (output op_valid, output op_write, output register_select_pin,
    output op_addr, output wdata, input rdata, input rvalid);
endinterface

// ==== src/pcb_burst_addr.sv ====
// Next burst address generator from the bus setup register fields.
// Assumes a combinational caller on the same clock.
`timescale 1ns/1ps
module pcb_burst_addr
  import pcb_pkg::*;
#(
  parameter int AW = ADDR_W,
  // Code to length table, codes 1..4 give 4,8,16,32 words
  parameter logic [5:0] LEN_TABLE [8] = '{6'd0, 6'd0, 6'd0, 6'd32, 6'd16, 6'd8, 6'd4, 6'd0}
) (
  input wire logic [AW-1:0] cur_addr,
  input wire logic [2:0] len_code,
  input wire logic no_wrap,
  output logic [AW-1:0] next_addr,
  output logic [5:0] burst_len
);
  logic [AW-1:0] mask;
  always_comb begin
    burst_len = LEN_TABLE[3'h7 - len_code]; // see R17
    mask = AW'(burst_len) - AW'(1);
    if (len_code == BL_CONT || burst_len == 6'd0 || no_wrap) begin
      next_addr = cur_addr + AW'(1); // see R13 see R15
    end else begin
      next_addr = (cur_addr & ~mask) | ((cur_addr + AW'(1)) & mask); // see R14
    end
  end
endmodule

// ==== src/pcb_mem_dev.sv ====
// Memory-side register block: bus and refresh setup registers, software sequence,
// and the burst address stepper. Assumes link inputs are from on-chip logic.
// What this block does
// R1: Two reads then two writes load register
// R2: Fourth op read returns selected register
// R3: All sequence ops hit top address
// R4: Top address contents stay unchanged
// R5: Third write 0000h refresh, 0001h bus
// R6: Fourth op moves all sixteen bits
// R7: Pin-selected access still works
// R8: Bus setup register resets to 9D1Fh
// R9: Bus setup by pin code 10b or 0001h
// R10: Wrap and length govern writes too
// R11: Registers read back exactly as written
// R12: Length field selects 4-32 or continuous
// R13: Continuous burst rolls over to zero
// R14: Bit 3 chooses wrap or sequential
// R15: No wrap fixed bursts cross boundaries
// R16: Drive code 00 full, 01 half, 10 quarter
// R17: Length codes come from constant table
// R18: Other address abandons the sequence
`timescale 1ns/1ps
module pcb_mem_dev
  import pcb_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  pcb_if.dev link,
  input wire logic burst_start,
  input wire logic burst_step,
  input wire logic [ADDR_W-1:0] burst_base,
  output logic [ADDR_W-1:0] burst_addr,
  output logic [1:0] drive_strength,
  output logic drive_reserved
);
  typedef enum {S_IDLE, S_R1, S_R2, S_W3} pcb_seq_t;
  pcb_seq_t seq_q;
  logic [15:0] bus_setup_q;
  logic [15:0] refresh_setup_q;
  logic sel_bus_q;
  logic [15:0] array_q [DEPTH];
  logic [15:0] top_word_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] next_addr;
  logic at_top;
  logic pin_op;
  logic array_op;
  logic sw_fourth;

  assign at_top = link.op_addr == TOP_ADDR;
  assign pin_op = link.op_valid && link.register_select_pin; // see R7
  assign sw_fourth = link.op_valid && !link.register_select_pin && at_top && seq_q == S_W3;
  assign array_op = link.op_valid && !link.register_select_pin && !sw_fourth;

  // Sequence tracker; any off-top access without the select pin drops it and runs as array op
  always_ff @(posedge core_clk) begin
    if (rst) begin
      seq_q <= S_IDLE;
      sel_bus_q <= 1'b0;
    end else if (link.op_valid && !link.register_select_pin) begin
      if (!at_top) begin
        seq_q <= S_IDLE; // see R18 see R3
      end else begin
        unique case (seq_q)
          S_IDLE: seq_q <= link.op_write ? S_IDLE : S_R1; // see R1
          S_R1: seq_q <= link.op_write ? S_IDLE : S_R2;
          S_R2: begin
            seq_q <= link.op_write ? S_W3 : S_R2;
            sel_bus_q <= link.wdata == SEL_BUS; // see R5
          end
          S_W3: seq_q <= S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_setup_q <= BUS_SETUP_RESET; // see R8
      refresh_setup_q <= REFRESH_SETUP_RESET;
    end else if (sw_fourth && link.op_write) begin
      if (sel_bus_q) bus_setup_q <= link.wdata; // see R6 see R11
      else refresh_setup_q <= link.wdata;
    end else if (pin_op && link.op_write) begin
      if (link.op_addr[PIN_SEL_LO+:2] == PIN_SEL_BUS) bus_setup_q <= link.wdata; // see R9
      else if (link.op_addr[PIN_SEL_LO+:2] == PIN_SEL_REFRESH) refresh_setup_q <= link.wdata;
    end
  end

  // Third write of a sequence is a selector, so top word is never written then
  // Top word cleared on reset so early sequence reads never return unknowns
  always_ff @(posedge core_clk) begin
    if (rst) begin
      top_word_q <= 16'h0000;
    end else if (array_op && link.op_write && at_top && seq_q != S_R2) begin
      top_word_q <= link.wdata; // see R4
    end
  end

  always_ff @(posedge core_clk) begin
    if (array_op && link.op_write && !at_top) begin
      array_q[link.op_addr[$clog2(DEPTH)-1:0]] <= link.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      rvalid_q <= link.op_valid && !link.op_write;
      if (link.op_valid && !link.op_write) begin
        if (sw_fourth) rdata_q <= sel_bus_q ? bus_setup_q : refresh_setup_q; // see R2
        else if (pin_op) begin
          rdata_q <= (link.op_addr[PIN_SEL_LO+:2] == PIN_SEL_BUS) ? bus_setup_q :
                     (link.op_addr[PIN_SEL_LO+:2] == PIN_SEL_REFRESH) ? refresh_setup_q :
                     16'h0000;
        end else if (at_top) rdata_q <= top_word_q;
        else rdata_q <= array_q[link.op_addr[$clog2(DEPTH)-1:0]];
      end
    end
  end
  assign link.rdata = rdata_q;
  assign link.rvalid = rvalid_q;

  // Same stepper for read and write bursts
  pcb_burst_addr u_step (
    .cur_addr(addr_q),
    .len_code(bus_setup_q[BL_LO+:3]), // see R12
    .no_wrap(bus_setup_q[WRAP_BIT]),
    .next_addr(next_addr),
    .burst_len()
  );
  always_ff @(posedge core_clk) begin
    if (rst) addr_q <= '0;
    else if (burst_start) addr_q <= burst_base;
    else if (burst_step) addr_q <= next_addr; // see R10
  end
  assign burst_addr = addr_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_strength <= DRIVE_HALF;
      drive_reserved <= 1'b0;
    end else begin
      drive_strength <= bus_setup_q[DRIVE_LO+:2]; // see R16
      drive_reserved <= &bus_setup_q[DRIVE_LO+:2];
    end
  end
endmodule

// ==== src/pcb_mem_ctl.sv ====
// Controller end: APB slave that runs single ops or the four-op software sequence.
// Assumes the device answers reads one cycle after the op strobe.
`timescale 1ns/1ps
module pcb_mem_ctl
  import pcb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pcb_if.ctl link
);
  typedef enum {C_IDLE, C_OP, C_WAIT} pcb_cst_t;
  pcb_cst_t st_q;
  logic [15:0] ctrl_q;
  logic [ADDR_W-1:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [1:0] step_q;
  logic multi_q;
  logic busy;
  logic acc;
  logic op_valid_q;
  logic op_write_q;
  logic rsp_q;
  logic [ADDR_W-1:0] op_addr_q;
  logic [15:0] op_wdata_q;

  assign busy = st_q != C_IDLE;
  assign acc = psel && penable && !pready;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_q <= 16'h0000;
      addr_q <= '0;
      wdata_q <= 16'h0000;
    end else begin
      pready <= acc;
      pslverr <= 1'b0;
      if (acc) begin
        prdata <= 32'h0000_0000;
        if (pwrite) begin
          unique case (paddr)
            OFF_CTRL: if (!busy) ctrl_q <= pwdata[15:0];
            OFF_ADDR: addr_q <= pwdata[ADDR_W-1:0];
            OFF_WDATA: wdata_q <= pwdata[15:0];
            default: pslverr <= !(paddr == OFF_RDATA || paddr == OFF_STATUS);
          endcase
        end else begin
          unique case (paddr)
            OFF_CTRL: prdata <= {16'h0000, ctrl_q};
            OFF_ADDR: prdata <= {9'h000, addr_q};
            OFF_WDATA: prdata <= {16'h0000, wdata_q};
            OFF_RDATA: prdata <= {16'h0000, rdata_q};
            OFF_STATUS: prdata <= {31'h0, busy};
            default: pslverr <= 1'b1;
          endcase
        end
      end else if (ctrl_q[CTRL_GO] && st_q == C_OP) begin
        ctrl_q[CTRL_GO] <= 1'b0;
      end
    end
  end

  // Software ops: read, read, write selector, then read or write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= C_IDLE;
      step_q <= 2'd0;
      multi_q <= 1'b0;
      op_valid_q <= 1'b0;
      op_write_q <= 1'b0;
      rsp_q <= 1'b0;
      op_addr_q <= '0;
      op_wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      op_valid_q <= 1'b0;
      unique case (st_q)
        C_IDLE: if (ctrl_q[CTRL_GO]) begin
          multi_q <= ctrl_q[2:0] == PCB_CMD_SW_LOAD || ctrl_q[2:0] == PCB_CMD_SW_READ;
          step_q <= 2'd0;
          st_q <= C_OP;
        end
        C_OP: begin
          op_valid_q <= 1'b1;
          rsp_q <= 1'b0;
          op_addr_q <= multi_q ? TOP_ADDR : addr_q; // see R3
          op_wdata_q <= wdata_q;
          op_write_q <= ctrl_q[2:0] == PCB_CMD_WR;
          if (multi_q) begin
            unique case (step_q)
              2'd0, 2'd1: op_write_q <= 1'b0; // see R1
              2'd2: begin
                op_write_q <= 1'b1;
                op_wdata_q <= ctrl_q[CTRL_REGSEL] ? SEL_BUS : SEL_REFRESH; // see R5 see R9
              end
              2'd3: op_write_q <= ctrl_q[2:0] == PCB_CMD_SW_LOAD; // see R2
            endcase
          end
          st_q <= C_WAIT;
        end
        C_WAIT: begin
          if (op_write_q || rsp_q || link.rvalid) begin
            if (link.rvalid) rdata_q <= link.rdata; // see R6
            if (multi_q && step_q != 2'd3) begin
              step_q <= step_q + 2'd1;
              st_q <= C_OP;
            end else st_q <= C_IDLE;
          end
          rsp_q <= 1'b1;
        end
      endcase
    end
  end

  assign link.op_valid = op_valid_q;
  assign link.op_write = op_write_q;
  assign link.op_addr = op_addr_q;
  assign link.wdata = op_wdata_q;
  assign link.register_select_pin = 1'b0; // see R7
endmodule

// ==== testbench/pcb_link_monitor.sv ====
// Checker on the memory link between controller and register block.
// Assumes one clock; the controller issues each software sequence whole.
`timescale 1ns/1ps
module pcb_link_monitor
  import pcb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic op_write,
  input wire logic register_select_pin,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  logic [1:0] step_q;
  logic sel_q, seen_q, top_ok_q;
  logic [15:0] bus_q, ref_q, top_q;
  wire logic top = op_valid && op_addr == TOP_ADDR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shadow of both setup registers and the top word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      step_q <= 2'h0;
      seen_q <= 1'b0;
      top_ok_q <= 1'b0;
      bus_q <= BUS_SETUP_RESET;
      ref_q <= REFRESH_SETUP_RESET;
    end else begin
      if (rvalid) seen_q <= 1'b1;
      if (op_valid) begin
        if (!top || step_q == 2'h3) step_q <= 2'h0;
        else if (step_q == 2'h2) step_q <= op_write ? 2'h3 : 2'h0;
        else step_q <= op_write ? 2'h0 : step_q + 2'h1;
        if (top && step_q == 2'h2) sel_q <= wdata == SEL_BUS;
        if (top && step_q == 2'h3 && op_write && sel_q) bus_q <= wdata;
        if (top && step_q == 2'h3 && op_write && !sel_q) ref_q <= wdata;
        if (top && step_q < 2'h2 && op_write) top_q <= wdata;
        if (top && step_q < 2'h2 && op_write) top_ok_q <= 1'b1;
      end
    end
  end
  rd_answer_a: assert property (
    op_valid && !op_write |=> rvalid) else $error("read op got no answer");
  rvalid_cause_a: assert property (
    rvalid |-> $past(op_valid) && !$past(op_write)) else $error("stray answer");
  write_quiet_a: assert property (
    op_valid && op_write |=> !rvalid) else $error("write op answered");
  op_spacing_a: assert property (
    op_valid && !op_write |=> !op_valid [*2]) else $error("ops too close");
  write_gap_a: assert property (
    op_valid && op_write |=> !op_valid) else $error("op right after write");
  pin_low_a: assert property (
    !register_select_pin) else $error("select pin driven");
  rdata_hold_a: assert property (
    seen_q && !rvalid |-> $stable(rdata)) else $error("read data moved");
  seq_third_a: assert property (
    op_valid && step_q == 2'h2 |-> top && op_write) else $error("bad third op");
  reg_read_a: assert property (
    top && !op_write && step_q == 2'h3 |=> rdata == (sel_q ? bus_q : ref_q))
    else $error("register read wrong");
  top_kept_a: assert property (
    top && !op_write && step_q < 2'h2 && top_ok_q |=> rdata == top_q)
    else $error("top word changed");
endmodule

// ==== testbench/tb_top.sv ====
// Bench joining controller and register block over the link, driven by APB.
// Assumes the hand-over timing: one wait state per APB access.
`timescale 1ns/1ps
module tb_top;
  import pcb_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, burst_start = 1'b0, burst_step = 1'b0, drive_reserved;
  logic [ADDR_W-1:0] burst_base = '0, burst_addr;
  logic [1:0] drive_strength;
  logic [15:0] v;
  int failures = 0, checks_done = 0, cycles = 0;
  pcb_if link ();
  pcb_mem_dev #(.DEPTH(16)) pcb_mem_dev_inst (.core_clk, .rst, .link, .burst_start,
    .burst_step, .burst_base, .burst_addr, .drive_strength, .drive_reserved);
  pcb_mem_ctl pcb_mem_ctl_inst (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link);
  pcb_link_monitor pcb_link_monitor_inst (.core_clk(core_clk), .rst(rst),
    .op_valid(link.op_valid), .op_write(link.op_write), .op_addr(link.op_addr),
    .register_select_pin(link.register_select_pin), .wdata(link.wdata),
    .rdata(link.rdata), .rvalid(link.rvalid));
  always #25 core_clk = ~core_clk;
  // Whole run needs under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls busy, then leaves the link result in rd
  task automatic cmd(input pcb_cmd_t c, input logic s, input logic [22:0] a,
    input logic [15:0] d);
    apb(1'b1, OFF_ADDR, {9'h0, a});
    apb(1'b1, OFF_WDATA, {16'h0, d});
    apb(1'b1, OFF_CTRL, {27'h0, s, 1'b1, c});
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
    end while (rd[0] !== 1'b0);
    apb(1'b0, OFF_RDATA, 32'h0);
  endtask
  task automatic t_regs();
    cmd(PCB_CMD_SW_READ, 1'b1, 23'h0, 16'h0);
    check("bus setup reset", rd[15:0], BUS_SETUP_RESET);
    check("drive reset", drive_strength, DRIVE_HALF);
    cmd(PCB_CMD_SW_READ, 1'b0, 23'h0, 16'h0);
    check("refresh reset", rd[15:0], REFRESH_SETUP_RESET);
    cmd(PCB_CMD_SW_LOAD, 1'b0, 23'h0, 16'h0013);
    cmd(PCB_CMD_SW_READ, 1'b0, 23'h0, 16'h0);
    check("refresh readback", rd[15:0], 16'h0013);
    for (int i = 0; i < 4; i++) begin
      v = 16'h9d0f | (16'(i) << 4);
      cmd(PCB_CMD_SW_LOAD, 1'b1, 23'h0, v);
      cmd(PCB_CMD_SW_READ, 1'b1, 23'h0, 16'h0);
      check("bus readback", rd[15:0], v);
      check("drive code", drive_strength, v[5:4]);
      check("drive reserved", drive_reserved, v[5:4] == 2'b11);
    end
    $display("t_regs done");
  endtask
  task automatic t_top();
    cmd(PCB_CMD_WR, 1'b0, TOP_ADDR, 16'h5a3c);
    cmd(PCB_CMD_SW_LOAD, 1'b1, 23'h0, 16'h9d1f);
    cmd(PCB_CMD_RD, 1'b0, TOP_ADDR, 16'h0);
    check("top word", rd[15:0], 16'h5a3c);
    cmd(PCB_CMD_WR, 1'b0, 23'h1, 16'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", err, 1'b1);
    $display("t_top done");
  endtask
  task automatic burst(input logic [15:0] cfg, input logic [22:0] b, e1, e2);
    cmd(PCB_CMD_SW_LOAD, 1'b1, 23'h0, cfg);
    @(posedge core_clk);
    burst_base <= b;
    burst_start <= 1'b1;
    @(posedge core_clk);
    burst_start <= 1'b0;
    burst_step <= 1'b1;
    @(posedge core_clk);
    check("burst start", burst_addr, b);
    @(posedge core_clk);
    check("burst step one", burst_addr, e1);
    burst_step <= 1'b0;
    @(posedge core_clk);
    check("burst step two", burst_addr, e2);
  endtask
  task automatic t_burst();
    burst(16'h9d11, 23'h13, 23'h10, 23'h11);
    burst(16'h9d12, 23'h0f, 23'h08, 23'h09);
    burst(16'h9d13, 23'h1f, 23'h10, 23'h11);
    burst(16'h9d14, 23'h3f, 23'h20, 23'h21);
    burst(16'h9d19, 23'h13, 23'h14, 23'h15);
    burst(16'h9d19, 23'h7ffffe, 23'h7fffff, 23'h0);
    burst(16'h9d17, 23'h7fffff, 23'h0, 23'h1);
    $display("t_burst done");
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_top();
    t_burst();
    complete_run();
  end
endmodule
